// ==== rtl/sync_slave_pkg.sv ====
// Constants, register map and carrier types for the synchronous slave serial port.
// Assumes a 32-bit APB slave with byte addresses and a pclk of 200 MHz.
package sync_slave_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TX_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TX_DATA = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h14;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h18;

  // transmit_status_control fields
  localparam int unsigned TXS_CLOCK_SOURCE_MASTER = 7;
  localparam int unsigned TXS_TX9 = 6;
  localparam int unsigned TXS_TRANSMIT_ENABLE = 5;
  localparam int unsigned TXS_SYNC = 4;
  localparam int unsigned TXS_TRMT = 1;
  localparam int unsigned TXS_TRANSMIT_NINTH_BIT = 0;

  // receive_status_control fields
  localparam int unsigned RXS_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned RXS_RX9 = 6;
  localparam int unsigned RXS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int unsigned RXS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned RXS_OVERRUN_ERROR_FLAG = 1;
  localparam int unsigned RXS_RECEIVED_NINTH_BIT = 0;

  // baud_and_clock_control, interrupt and pin control fields
  localparam int unsigned BAUD_RCIDL = 6;
  localparam int unsigned INT_GIE = 7;
  localparam int unsigned INT_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int unsigned INT_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int unsigned INT_TRANSMIT_INTERRUPT_ENABLE = 4;
  localparam int unsigned INT_RECEIVE_DATA_PENDING_FLAG = 1;
  localparam int unsigned INT_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
  localparam int unsigned PIN_ANALOG_INPUT_SELECT_TIMING = 0;
  localparam int unsigned PIN_ANALOG_INPUT_SELECT_LINE = 1;

  // Reset values and fixed figures
  localparam logic [1:0] PIN_CTRL_RESET = 2'h3;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam logic [15:0] ISR_VECTOR = 16'h0004;

  typedef struct packed {
    logic clock_source_master;
    logic tx9;
    logic transmit_enable;
    logic sync;
    logic transmit_ninth_bit;
  } tx_ctl_t;

  typedef struct packed {
    logic serial_port_enable;
    logic rx9;
    logic single_receive_enable;
    logic continuous_receive_enable;
  } rx_ctl_t;

  typedef struct packed {
    logic global_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic receive_interrupt_enable;
    logic transmit_interrupt_enable;
  } int_ctl_t;

  typedef struct packed {
    logic analog_input_select_line;
    logic analog_input_select_timing;
  } pin_ctl_t;

  typedef struct packed {
    logic ninth;
    logic [7:0] low;
  } char_t;

  typedef enum logic [0:0] {
    TX_EMPTY = 1'b0,
    TX_SHIFTING = 1'b1
  } tx_state_t;

endpackage

// ==== rtl/sync_slave_serial_port.sv ====
// Synchronous slave serial port: transmit, receive and wake from Sleep.
// Assumes an APB master on pclk and an external master clocking the timing pin.
// What this block does
// - Queued word moves to shifter at once
// - Buffer-empty flag set each time the shifter loads
// - Transmit event wakes; vectors only with global enable
// - Slave transmit needs sync, enable, no receive
// - Transmit enable arms; buffer write starts sending
// - Nine-bit mode sends ninth bit last
// - Slave receive follows continuous enable, ignores single
// - Sleep reception loads buffer and wakes core
// - Completed character sets pending flag, interrupt
// - Received ninth bit shown in status field
// - Overrun clears with receive or port disable
// - Only slave mode shifts during Sleep
// - Shifters advance only on external clock edges
// - Reading buffer unloads; flag clears when empty
// - Whole clocked word sets pending flag, wakes
// - Wake resumes, or calls vector with global enable
// - Buffer write clears empty flag
// - Shift done reloads buffered byte, sets flag
// - Another write clears the empty flag again
// - Transmit wake needs both interrupt enables
// - Pins serve only with analog select clear
// - Clock driver off; one bit per clock
// - Change on leading edge, sample on trailing
// - Two-deep buffer; third character sets overrun
`timescale 1ns/1ps
module sync_slave_serial_port #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_timing_pin_in,
  output logic serial_timing_pin_out,
  output logic serial_timing_pin_oe,
  input wire logic serial_line_pin_in,
  output logic serial_line_pin_out,
  output logic serial_line_pin_oe,
  // Core sleep and interrupt
  input wire logic sleep_mode,
  output logic irq_req,
  output logic wake_req,
  output logic isr_call,
  output logic [15:0] isr_addr
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  function automatic logic [3:0] word_bits(input logic ninth_sel);
    word_bits = ninth_sel ? sync_slave_pkg::BITS_LONG : sync_slave_pkg::BITS_SHORT;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == sync_slave_pkg::ADDR_TX_STATUS) || (a == sync_slave_pkg::ADDR_RX_STATUS) ||
              (a == sync_slave_pkg::ADDR_TX_DATA) || (a == sync_slave_pkg::ADDR_RX_DATA) ||
              (a == sync_slave_pkg::ADDR_BAUD) || (a == sync_slave_pkg::ADDR_INT_CTRL) ||
              (a == sync_slave_pkg::ADDR_PIN_CTRL);
  endfunction

  sync_slave_pkg::tx_ctl_t tx_ctl_q;
  sync_slave_pkg::rx_ctl_t rx_ctl_q;
  sync_slave_pkg::int_ctl_t int_ctl_q;
  sync_slave_pkg::pin_ctl_t pin_ctl_q;
  sync_slave_pkg::tx_state_t tx_state_q;
  sync_slave_pkg::char_t tx_buf_q;
  sync_slave_pkg::char_t fifo_q [FIFO_DEPTH];
  sync_slave_pkg::char_t rx_char;
  sync_slave_pkg::char_t fifo_top;

  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic pready_q, pslverr_q, pop_ok_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q, ck_lvl_q;
  logic line_s1_q, line_s2_q, line_s3_q;
  logic ck_agree, ck_rise, ck_fall, line_bit;
  logic tx_buf_full_q, line_out_q, line_oe_q, ck_out_q, ck_oe_q;
  logic [8:0] tsr_q, rsr_q;
  logic [3:0] tx_cnt_q, rx_cnt_q;
  logic [CW-1:0] fifo_cnt_q;
  logic [PW-1:0] rd_ptr_q, wr_ptr;
  logic overrun_error_flag_q, irq_q, wake_q, isr_call_q;
  logic [15:0] isr_addr_q;
  logic slave_mode, tx_active, rx_active, setup, access, wr_acc, rd_acc;
  logic load_tsr, tx_wr, rx_done, push, pop, overrun, transmit_buffer_empty_flag, receive_data_pending_flag, tx_evt, rx_evt;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_timing_pin_out = ck_out_q;
  assign serial_timing_pin_oe = ck_oe_q;
  assign serial_line_pin_out = line_out_q;
  assign serial_line_pin_oe = line_oe_q;
  assign irq_req = irq_q;
  assign wake_req = wake_q;
  assign isr_call = isr_call_q;
  assign isr_addr = isr_addr_q;

  // Mode decode
  assign slave_mode = rx_ctl_q.serial_port_enable & tx_ctl_q.sync & ~tx_ctl_q.clock_source_master;
  assign tx_active = slave_mode & tx_ctl_q.transmit_enable & ~rx_ctl_q.continuous_receive_enable & ~rx_ctl_q.single_receive_enable;
  // Single receive enable plays no part in slave reception
  assign rx_active = slave_mode & rx_ctl_q.continuous_receive_enable & ~overrun_error_flag_q;

  // APB handshake
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign wr_acc = access & pwrite & pstrb[0];
  assign rd_acc = access & ~pwrite;

  // Three-stage synchronisers; stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      line_s1_q <= 1'b0;
      line_s2_q <= 1'b0;
      line_s3_q <= 1'b0;
    end else begin
      ck_s1_q <= serial_timing_pin_in;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      line_s1_q <= serial_line_pin_in;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q;
    end
  end

  // Clock level accepted only when stages agree; analog select blanks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_lvl_q <= 1'b0;
    end else if (pin_ctl_q.analog_input_select_timing) begin
      ck_lvl_q <= 1'b0;
    end else if (ck_s2_q == ck_s3_q) begin
      ck_lvl_q <= ck_s3_q;
    end
  end

  // Idle-low clock: rising is leading, falling is trailing
  // Edge from agreeing stages directly, so a bit is out within half a link period
  assign ck_agree = ~pin_ctl_q.analog_input_select_timing & (ck_s2_q == ck_s3_q);
  assign ck_rise = ck_agree & ck_s3_q & ~ck_lvl_q;
  assign ck_fall = ck_agree & ~ck_s3_q & ck_lvl_q;
  assign line_bit = pin_ctl_q.analog_input_select_line ? 1'b0 : line_s3_q;

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctl_q <= '0;
    end else if (wr_acc && paddr == sync_slave_pkg::ADDR_TX_STATUS) begin
      tx_ctl_q.clock_source_master <= pwdata[sync_slave_pkg::TXS_CLOCK_SOURCE_MASTER];
      tx_ctl_q.tx9 <= pwdata[sync_slave_pkg::TXS_TX9];
      tx_ctl_q.transmit_enable <= pwdata[sync_slave_pkg::TXS_TRANSMIT_ENABLE];
      tx_ctl_q.sync <= pwdata[sync_slave_pkg::TXS_SYNC];
      tx_ctl_q.transmit_ninth_bit <= pwdata[sync_slave_pkg::TXS_TRANSMIT_NINTH_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ctl_q <= '0;
    end else if (wr_acc && paddr == sync_slave_pkg::ADDR_RX_STATUS) begin
      rx_ctl_q.serial_port_enable <= pwdata[sync_slave_pkg::RXS_SERIAL_PORT_ENABLE];
      rx_ctl_q.rx9 <= pwdata[sync_slave_pkg::RXS_RX9];
      rx_ctl_q.single_receive_enable <= pwdata[sync_slave_pkg::RXS_SINGLE_RECEIVE_ENABLE];
      rx_ctl_q.continuous_receive_enable <= pwdata[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctl_q <= '0;
      pin_ctl_q <= sync_slave_pkg::PIN_CTRL_RESET;
    end else if (wr_acc && paddr == sync_slave_pkg::ADDR_INT_CTRL) begin
      int_ctl_q.global_interrupt_enable <= pwdata[sync_slave_pkg::INT_GIE];
      int_ctl_q.peripheral_interrupt_enable <= pwdata[sync_slave_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE];
      int_ctl_q.receive_interrupt_enable <= pwdata[sync_slave_pkg::INT_RECEIVE_INTERRUPT_ENABLE];
      int_ctl_q.transmit_interrupt_enable <= pwdata[sync_slave_pkg::INT_TRANSMIT_INTERRUPT_ENABLE];
    end else if (wr_acc && paddr == sync_slave_pkg::ADDR_PIN_CTRL) begin
      pin_ctl_q.analog_input_select_line <= pwdata[sync_slave_pkg::PIN_ANALOG_INPUT_SELECT_LINE];
      pin_ctl_q.analog_input_select_timing <= pwdata[sync_slave_pkg::PIN_ANALOG_INPUT_SELECT_TIMING];
    end
  end

  // Transmit buffer; a write while full is dropped
  assign tx_wr = wr_acc && paddr == sync_slave_pkg::ADDR_TX_DATA;
  assign load_tsr = tx_active && tx_state_q == sync_slave_pkg::TX_EMPTY && tx_buf_full_q;
  assign transmit_buffer_empty_flag = ~tx_buf_full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q <= '0;
      tx_buf_full_q <= 1'b0;
    end else if (!rx_ctl_q.serial_port_enable) begin
      tx_buf_full_q <= 1'b0;
    end else if (tx_wr && !tx_buf_full_q) begin
      tx_buf_q.low <= pwdata[7:0];
      tx_buf_q.ninth <= tx_ctl_q.tx9 & tx_ctl_q.transmit_ninth_bit;
      tx_buf_full_q <= 1'b1;
    end else if (load_tsr) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  // Transmit shifter: new bit on leading edge, word ends at last trailing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= sync_slave_pkg::TX_EMPTY;
      tsr_q <= '0;
      tx_cnt_q <= '0;
      line_out_q <= 1'b0;
    end else if (!tx_active) begin
      tx_state_q <= sync_slave_pkg::TX_EMPTY;
      tx_cnt_q <= '0;
    end else begin
      case (tx_state_q)
        sync_slave_pkg::TX_EMPTY: begin
          if (load_tsr) begin
            tsr_q <= tx_buf_q;
            tx_cnt_q <= '0;
            tx_state_q <= sync_slave_pkg::TX_SHIFTING;
          end
        end
        sync_slave_pkg::TX_SHIFTING: begin
          if (ck_rise && tx_cnt_q != word_bits(tx_ctl_q.tx9)) begin
            line_out_q <= tsr_q[0];
            tsr_q <= {1'b0, tsr_q[8:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end else if (ck_fall && tx_cnt_q == word_bits(tx_ctl_q.tx9)) begin
            tx_state_q <= sync_slave_pkg::TX_EMPTY;
          end
        end
        default: begin
          tx_state_q <= sync_slave_pkg::TX_EMPTY;
        end
      endcase
    end
  end

  // Pin drivers: the timing pin is never driven in slave mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_oe_q <= 1'b0;
      ck_out_q <= 1'b0;
      ck_oe_q <= 1'b0;
    end else begin
      line_oe_q <= tx_active & ~pin_ctl_q.analog_input_select_line;
      ck_out_q <= 1'b0;
      ck_oe_q <= 1'b0;
    end
  end

  // Receive shifter samples on trailing edge, lowest bit first
  assign rx_done = rx_active && ck_fall && rx_cnt_q == word_bits(rx_ctl_q.rx9) - 4'h1;
  always_comb begin
    rx_char = '0;
    if (rx_ctl_q.rx9) begin
      rx_char.low = rsr_q[7:0];
      rx_char.ninth = line_bit;
    end else begin
      rx_char.low = {line_bit, rsr_q[6:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_q <= '0;
      rx_cnt_q <= '0;
    end else if (!rx_active) begin
      rx_cnt_q <= '0; // Partial character is discarded
    end else if (ck_fall) begin
      rsr_q[rx_cnt_q] <= line_bit;
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // Two-deep receive buffer; a full buffer refuses the third character
  assign wr_ptr = PW'((rd_ptr_q + fifo_cnt_q) % FIFO_DEPTH);
  assign push = rx_done && fifo_cnt_q != CW'(FIFO_DEPTH);
  assign overrun = rx_done && fifo_cnt_q == CW'(FIFO_DEPTH);
  assign pop = rd_acc && pop_ok_q && paddr == sync_slave_pkg::ADDR_RX_DATA;
  assign receive_data_pending_flag = fifo_cnt_q != '0;
  assign fifo_top = fifo_q[rd_ptr_q];

  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_q[wr_ptr] <= rx_char;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_cnt_q <= '0;
      rd_ptr_q <= '0;
    end else if (!rx_ctl_q.serial_port_enable) begin
      fifo_cnt_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (pop) begin
        rd_ptr_q <= PW'((rd_ptr_q + 1'b1) % FIFO_DEPTH);
      end
      if (push && !pop) begin
        fifo_cnt_q <= fifo_cnt_q + 1'b1;
      end else if (pop && !push) begin
        fifo_cnt_q <= fifo_cnt_q - 1'b1;
      end
    end
  end

  // Overrun holds until reception or the port is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_q <= 1'b0;
    end else if (!rx_ctl_q.serial_port_enable || !rx_ctl_q.continuous_receive_enable) begin
      overrun_error_flag_q <= 1'b0;
    end else if (overrun) begin
      overrun_error_flag_q <= 1'b1;
    end
  end

  // Wake and vector requests toward the core
  assign tx_evt = transmit_buffer_empty_flag & int_ctl_q.transmit_interrupt_enable & int_ctl_q.peripheral_interrupt_enable;
  assign rx_evt = receive_data_pending_flag & int_ctl_q.receive_interrupt_enable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      isr_call_q <= 1'b0;
      isr_addr_q <= '0;
    end else begin
      irq_q <= tx_evt | rx_evt;
      wake_q <= sleep_mode & (tx_evt | rx_evt);
      isr_call_q <= (tx_evt | rx_evt) & int_ctl_q.global_interrupt_enable;
      isr_addr_q <= sync_slave_pkg::ISR_VECTOR;
    end
  end

  // Read data is frozen at setup so a pop matches what was returned
  always_comb begin
    rd_mux = '0;
    case (paddr)
      sync_slave_pkg::ADDR_TX_STATUS: begin
        rd_mux[sync_slave_pkg::TXS_CLOCK_SOURCE_MASTER] = tx_ctl_q.clock_source_master;
        rd_mux[sync_slave_pkg::TXS_TX9] = tx_ctl_q.tx9;
        rd_mux[sync_slave_pkg::TXS_TRANSMIT_ENABLE] = tx_ctl_q.transmit_enable;
        rd_mux[sync_slave_pkg::TXS_SYNC] = tx_ctl_q.sync;
        rd_mux[sync_slave_pkg::TXS_TRMT] = tx_state_q == sync_slave_pkg::TX_EMPTY;
        rd_mux[sync_slave_pkg::TXS_TRANSMIT_NINTH_BIT] = tx_ctl_q.transmit_ninth_bit;
      end
      sync_slave_pkg::ADDR_RX_STATUS: begin
        rd_mux[sync_slave_pkg::RXS_SERIAL_PORT_ENABLE] = rx_ctl_q.serial_port_enable;
        rd_mux[sync_slave_pkg::RXS_RX9] = rx_ctl_q.rx9;
        rd_mux[sync_slave_pkg::RXS_SINGLE_RECEIVE_ENABLE] = rx_ctl_q.single_receive_enable;
        rd_mux[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE_ENABLE] = rx_ctl_q.continuous_receive_enable;
        rd_mux[sync_slave_pkg::RXS_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
        rd_mux[sync_slave_pkg::RXS_RECEIVED_NINTH_BIT] = receive_data_pending_flag & fifo_top.ninth;
      end
      sync_slave_pkg::ADDR_RX_DATA: begin
        rd_mux[7:0] = receive_data_pending_flag ? fifo_top.low : 8'h00;
      end
      sync_slave_pkg::ADDR_BAUD: begin
        rd_mux[sync_slave_pkg::BAUD_RCIDL] = ~(slave_mode & rx_ctl_q.continuous_receive_enable);
      end
      sync_slave_pkg::ADDR_INT_CTRL: begin
        rd_mux[sync_slave_pkg::INT_GIE] = int_ctl_q.global_interrupt_enable;
        rd_mux[sync_slave_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE] = int_ctl_q.peripheral_interrupt_enable;
        rd_mux[sync_slave_pkg::INT_RECEIVE_INTERRUPT_ENABLE] = int_ctl_q.receive_interrupt_enable;
        rd_mux[sync_slave_pkg::INT_TRANSMIT_INTERRUPT_ENABLE] = int_ctl_q.transmit_interrupt_enable;
        rd_mux[sync_slave_pkg::INT_RECEIVE_DATA_PENDING_FLAG] = receive_data_pending_flag;
        rd_mux[sync_slave_pkg::INT_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
      end
      sync_slave_pkg::ADDR_PIN_CTRL: begin
        rd_mux[sync_slave_pkg::PIN_ANALOG_INPUT_SELECT_LINE] = pin_ctl_q.analog_input_select_line;
        rd_mux[sync_slave_pkg::PIN_ANALOG_INPUT_SELECT_TIMING] = pin_ctl_q.analog_input_select_timing;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // No wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      pop_ok_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_ok(paddr);
      prdata_q <= (setup && !pwrite) ? rd_mux : '0;
      pop_ok_q <= setup & ~pwrite & receive_data_pending_flag;
    end
  end

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_tx_load;
    load_tsr |=> tx_state_q == sync_slave_pkg::TX_SHIFTING && !tx_buf_full_q;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("buffered word not moved to shifter");

  property p_transmit_buffer_empty_flag_rise;
    $rose(transmit_buffer_empty_flag) && rx_ctl_q.serial_port_enable |-> $past(load_tsr);
  endproperty
  a_transmit_buffer_empty_flag_rise: assert property (p_transmit_buffer_empty_flag_rise) else $error("empty flag set without a load");

  property p_wake_tx;
    sleep_mode && transmit_buffer_empty_flag && int_ctl_q.transmit_interrupt_enable && int_ctl_q.peripheral_interrupt_enable |=> wake_q;
  endproperty
  a_wake_tx: assert property (p_wake_tx) else $error("transmit event failed to wake");

  property p_no_vector;
    !int_ctl_q.global_interrupt_enable [*2] |-> !isr_call_q;
  endproperty
  a_no_vector: assert property (p_no_vector) else $error("vector call without global enable");

  property p_rx_push;
    rx_done && fifo_cnt_q == '0 |=> receive_data_pending_flag ##1 (irq_q || !$past(int_ctl_q.receive_interrupt_enable));
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("character did not set pending flag");

  property p_overrun;
    overrun && !pop |=> overrun_error_flag_q && fifo_cnt_q == CW'(FIFO_DEPTH);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or data lost");

  property p_overrun_error_flag_clear;
    overrun_error_flag_q && !rx_ctl_q.continuous_receive_enable |=> !overrun_error_flag_q;
  endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear) else $error("overrun not cleared");

  property p_pop_last;
    pop && fifo_cnt_q == CW'(1) && !push |=> !receive_data_pending_flag;
  endproperty
  a_pop_last: assert property (p_pop_last) else $error("pending flag stuck after last read");

  property p_ck_off;
    !ck_oe_q;
  endproperty
  a_ck_off: assert property (p_ck_off) else $error("timing pin driven in slave mode");

  property p_line_analog;
    pin_ctl_q.analog_input_select_line |=> !line_oe_q;
  endproperty
  a_line_analog: assert property (p_line_analog) else $error("line driven while analog");

  property p_no_shift_off;
    !slave_mode |=> rx_cnt_q == '0 && tx_state_q == sync_slave_pkg::TX_EMPTY;
  endproperty
  a_no_shift_off: assert property (p_no_shift_off) else $error("shifting outside slave mode");

  c_rx_char: cover property (push);
  c_tx_word: cover property (tx_state_q == sync_slave_pkg::TX_SHIFTING
    ##1 tx_state_q == sync_slave_pkg::TX_EMPTY ##1 $rose(transmit_buffer_empty_flag));
  c_overrun: cover property ($rose(overrun_error_flag_q));
  c_sleep_wake: cover property (sleep_mode && wake_q);

endmodule

// ==== bench/link_master_model.sv ====
// Behavioural external master that clocks the slave's serial link.
// Assumes the device syncs the timing pin into pclk; the link clock idles low.
`timescale 1ns/1ps
module link_master_model (
  // Link pins toward the device
  output logic link_clk,
  output logic link_data,
  // Device transmit data
  input wire logic line_out
);
  initial begin
    link_clk = 1'h0;
    link_data = 1'h1;
  end

  // One whole word per call; clock stands still between words
  task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h0;
    #3;
    for (int i = 0; i < n; i++) begin
      link_clk = 1'h1;
      link_data = tx[i]; // Lsb first, change on leading edge
      #24;
      rx[i] = line_out; // Sample on trailing edge
      link_clk = 1'h0;
      #24;
    end
    // No pull on the line, so a stale bit must not look valid
    link_data = ~link_data;
    #100;
  endtask
endmodule

// ==== bench/test_sync_slave_serial_port.sv ====
// Self-checking bench: APB register tasks plus an external link master.
// Assumes the port map and field layout of sync_slave_pkg.
`timescale 1ns/1ps
module test_sync_slave_serial_port;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, ck_oe, ck_out, dt_out, dt_oe, irq_req, wake_req, isr_call, ck_in, dt_in;
  logic [15:0] isr_addr;
  logic [8:0] rx;
  int err_count, n_tests;

  sync_slave_serial_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_timing_pin_in(ck_in),
    .serial_timing_pin_out(ck_out), .serial_timing_pin_oe(ck_oe), .serial_line_pin_in(dt_in),
    .serial_line_pin_out(dt_out), .serial_line_pin_oe(dt_oe), .sleep_mode(sleep_mode),
    .irq_req(irq_req), .wake_req(wake_req), .isr_call(isr_call), .isr_addr(isr_addr));
  link_master_model link (.link_clk(ck_in), .link_data(dt_in), .line_out(dt_out));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      err_count++;
      finish_test();
    end
    r = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 8'h0);
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sleep_mode = 1'h0;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd(sync_slave_pkg::ADDR_PIN_CTRL);
    check("pin ctrl reset", r, {30'h0, sync_slave_pkg::PIN_CTRL_RESET});
    rd(8'h1c);
    check("unmapped error", {31'h0, serr}, 32'h1);
    check("unmapped data", r, 32'h0);
    $display("test registers done");

    // Slave transmit, two words queued, then Sleep
    wr(sync_slave_pkg::ADDR_RX_STATUS, 8'h80);
    wr(sync_slave_pkg::ADDR_TX_STATUS, 8'h71);
    wr(sync_slave_pkg::ADDR_TX_DATA, 8'h5a);
    wr(sync_slave_pkg::ADDR_TX_DATA, 8'hc3);
    check("line oe analog", {31'h0, dt_oe}, 32'h0);
    wr(sync_slave_pkg::ADDR_PIN_CTRL, 8'h0);
    repeat (3) @(posedge pclk);
    check("line oe", {31'h0, dt_oe}, 32'h1);
    check("clock oe", {31'h0, ck_oe}, 32'h0);
    check("clock out", {31'h0, ck_out}, 32'h0);
    rd(sync_slave_pkg::ADDR_INT_CTRL);
    check("transmit_buffer_empty_flag queued", r[0], 32'h0);
    wr(sync_slave_pkg::ADDR_INT_CTRL, 8'h10);
    sleep_mode <= 1'h1;
    link.frame(9'h0, 9, rx);
    check("tx word 1", rx, 32'h15a);
    check("wake no peripheral_interrupt_enable", {31'h0, wake_req}, 32'h0);
    rd(sync_slave_pkg::ADDR_INT_CTRL);
    check("transmit_buffer_empty_flag reload", r[0], 32'h1);
    wr(sync_slave_pkg::ADDR_INT_CTRL, 8'hd0);
    repeat (3) @(posedge pclk);
    check("tx wake", {31'h0, wake_req}, 32'h1);
    check("isr call", {31'h0, isr_call}, 32'h1);
    check("isr addr", {16'h0, isr_addr}, {16'h0, sync_slave_pkg::ISR_VECTOR});
    wr(sync_slave_pkg::ADDR_TX_DATA, 8'h96);
    rd(sync_slave_pkg::ADDR_INT_CTRL);
    check("transmit_buffer_empty_flag refill", r[0], 32'h0);
    check("wake gone", {31'h0, wake_req}, 32'h0);
    link.frame(9'h0, 9, rx);
    check("tx word 2", rx, 32'h1c3);
    wr(sync_slave_pkg::ADDR_RX_STATUS, 8'h0);
    $display("test transmit done");

    // Slave receive in Sleep; single enable set but must not matter
    wr(sync_slave_pkg::ADDR_TX_STATUS, 8'h10);
    wr(sync_slave_pkg::ADDR_INT_CTRL, 8'h20);
    wr(sync_slave_pkg::ADDR_RX_STATUS, 8'hf0);
    link.frame(9'h1a5, 9, rx);
    check("rx irq", {31'h0, irq_req}, 32'h1);
    check("rx wake", {31'h0, wake_req}, 32'h1);
    link.frame(9'h03c, 9, rx);
    link.frame(9'h1f0, 9, rx);
    rd(sync_slave_pkg::ADDR_RX_STATUS);
    check("overrun ninth", r[1:0], 32'h3);
    rd(sync_slave_pkg::ADDR_RX_DATA);
    check("rx data 1", r, 32'ha5);
    rd(sync_slave_pkg::ADDR_RX_STATUS);
    check("ninth 2", r[0], 32'h0);
    rd(sync_slave_pkg::ADDR_RX_DATA);
    check("rx data 2", r, 32'h3c);
    rd(sync_slave_pkg::ADDR_INT_CTRL);
    check("receive_data_pending_flag empty", r[1], 32'h0);
    wr(sync_slave_pkg::ADDR_RX_STATUS, 8'he0);
    rd(sync_slave_pkg::ADDR_RX_STATUS);
    check("overrun clear", r[1], 32'h0);
    $display("test receive done");

    // Mid-run reset restores pin selects and flags
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    check("irq in reset", {31'h0, irq_req}, 32'h0);
    rd(sync_slave_pkg::ADDR_PIN_CTRL);
    check("pin ctrl re-reset", r, {30'h0, sync_slave_pkg::PIN_CTRL_RESET});
    rd(sync_slave_pkg::ADDR_INT_CTRL);
    check("flags after reset", r[1:0], 32'h1);
    $display("test reset done");
    finish_test();
  end
endmodule
